// ===== lag_defs.svh
`ifndef LAG_DEFS_SVH
`define LAG_DEFS_SVH

// Register byte offsets
`define LAG_OFF_STS      12'h000
`define LAG_OFF_SEG      12'h004
`define LAG_OFF_XPT      12'h008
`define LAG_OFF_ADDR     12'h00C
`define LAG_OFF_STAT     12'h010
`define LAG_OFF_PCR      12'h040

// Status word bit positions
`define LAG_STS_PTM      0
`define LAG_STS_DOUBLE   13
`define LAG_STS_PON      14

// Paging control entry fields
`define LAG_PCR_RING_HI  1
`define LAG_PCR_NORM_LO  6
`define LAG_PCR_ALT_LO   9

// Misc command field bits
`define LAG_MISC_ALT     0
`define LAG_MISC_WORD2   1
`define LAG_MISC_SHADOW  2

// Reset values and shadow window
`define LAG_RST_WORD     16'h0000
`define LAG_SHADOW_BASE  16'hFE00

`endif

// ===== lag_logical_address_generator.sv
`timescale 1ns/1ps
`default_nettype none
`include "lag_defs.svh"

module lag_logical_address_generator
  import lag_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  // Microcode command fields, unlatched
  input  wire logic [4:0]  MEM_CMD,
  input  wire logic [4:0]  MISC_CMD,
  input  wire logic [15:0] UWORD_ARG,
  // Processor level and register-file writes
  input  wire logic [3:0]  LEVEL,
  input  wire logic        RF_PC_WR,
  input  wire logic        RF_X_WR,
  input  wire logic        RF_B_WR,
  input  wire logic [15:0] RF_DATA,
  // Address to memory management
  output var  lag_addr_s   ADDR,
  output var  logic        ADDR_VALID,
  output var  logic        SHADOW,
  output var  logic [1:0]  RING,
  output var  logic        INSTR_FETCH,
  output var  logic        REFETCH,
  // Internal data bus drive
  output var  logic [15:0] BUS_DO,
  output var  logic        BUS_OE_N
);

  // Command latch
  lag_cmd_s    cmd_q;
  logic        go_q;
  // Address register copies
  logic [15:0] pc_q;
  logic [15:0] x_q;
  logic [15:0] b_q;
  // Software registers
  logic [15:0] sts_q;
  logic [15:0] seg_q;
  logic [15:0] xpt_q;
  logic [15:0] pcr_q [16];
  logic        refetch_q;
  // APB state
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  // Outputs
  lag_addr_s   addr_q;
  logic        valid_q;
  logic        shadow_q;
  logic [1:0]  ring_q;
  logic        ifetch_q;
  logic [15:0] bus_do_q;
  logic        bus_oe_n_q;

  // Command decode
  wire lag_op_e     op       = lag_op_e'(cmd_q.mem);
  wire logic        op_known = (cmd_q.mem <= OP_XPT);
  wire logic        cmd_go   = go_q && op_known && (op != OP_NONE);
  wire logic        is_fetch = cmd_go && (op == OP_FETCH);
  wire logic        is_jump  = cmd_go && (op == OP_JUMP);
  wire logic        page_table_mode_bit      = sts_q[`LAG_STS_PTM];
  wire logic        dbl      = sts_q[`LAG_STS_DOUBLE];
  wire logic        paging_on_flag      = sts_q[`LAG_STS_PON];
  wire logic [15:0] pcr_cur  = pcr_q[LEVEL];

  // Adder operands
  wire logic [15:0] base_v =
    (op == OP_XREL)                  ? x_q     :
    (op == OP_BREL || op == OP_BX)   ? b_q     :
    (op == OP_ABS)                   ? 16'h0000 :
    (op == OP_PCR)                   ? pcr_cur :
    (op == OP_SEG)                   ? seg_q   :
    (op == OP_XPT)                   ? xpt_q   : pc_q;
  wire logic [15:0] disp_v =
    (op == OP_FETCH)                 ? 16'h0000 :
    (op == OP_BX)                    ? x_q     : cmd_q.arg;
  wire logic        cin    = dbl && cmd_q.misc[`LAG_MISC_WORD2];
  wire logic [15:0] sum    = base_v + disp_v + {15'h0000, cin};

  // Page table selection
  wire logic        use_alt  = cmd_q.misc[`LAG_MISC_ALT] && !is_fetch;
  wire logic [2:0]  tbl_lo   = use_alt ? pcr_cur[`LAG_PCR_ALT_LO +: 3]
                                       : pcr_cur[`LAG_PCR_NORM_LO +: 3];
  wire logic [2:0]  tbl_hi   = page_table_mode_bit ? xpt_q[2:0] : 3'b000;
  wire logic [5:0]  tbl      = paging_on_flag ? {tbl_hi, tbl_lo} : 6'b000000;
  wire logic        shadow_d = cmd_q.misc[`LAG_MISC_SHADOW] ||
                               (!paging_on_flag && (sum >= `LAG_SHADOW_BASE));

  wire lag_addr_s   addr_d = '{spare:     4'h0,
                               table_sel: tbl,
                               vpage:     sum[15:10],
                               offset:    sum[9:0]};

  // Latch raw command fields every cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      cmd_q <= '0;
      go_q  <= 1'b0;
    end else begin
      cmd_q <= '{misc: MISC_CMD, mem: MEM_CMD, arg: UWORD_ARG};
      go_q  <= 1'b1;
    end
  end

  // Address register, held between commands
  always_ff @(posedge CLK) begin
    if (RST) begin
      addr_q   <= '0;
      shadow_q <= 1'b0;
      ring_q   <= 2'b00;
      ifetch_q <= 1'b0;
    end else if (cmd_go) begin
      addr_q   <= addr_d;
      shadow_q <= shadow_d;
      ring_q   <= pcr_cur[`LAG_PCR_RING_HI:0];
      ifetch_q <= is_fetch;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= cmd_go;
    end
  end

  // Private register copies
  always_ff @(posedge CLK) begin
    if (RST) begin
      pc_q <= `LAG_RST_WORD;
    end else if (RF_PC_WR) begin
      pc_q <= RF_DATA;
    end else if (is_jump) begin
      pc_q <= sum;
    end else if (is_fetch) begin
      pc_q <= pc_q + 16'h0001;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      x_q <= `LAG_RST_WORD;
      b_q <= `LAG_RST_WORD;
    end else begin
      if (RF_X_WR) begin
        x_q <= RF_DATA;
      end
      if (RF_B_WR) begin
        b_q <= RF_DATA;
      end
    end
  end

  // New fetch demanded; a write in the fetch cycle wins
  always_ff @(posedge CLK) begin
    if (RST) begin
      refetch_q <= 1'b0;
    end else if (RF_PC_WR) begin
      refetch_q <= 1'b1;
    end else if (is_fetch) begin
      refetch_q <= 1'b0;
    end
  end

  // Jump target onto internal bus for one cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      bus_do_q   <= 16'h0000;
      bus_oe_n_q <= 1'b1;
    end else begin
      bus_oe_n_q <= !is_jump;
      if (is_jump) begin
        bus_do_q <= sum;
      end
    end
  end

  // APB decode
  wire logic        setup    = PSEL && !PENABLE;
  wire logic        wr_en    = PSEL && PENABLE && pready_q && PWRITE;
  wire logic        hit_sts  = (PADDR == `LAG_OFF_STS);
  wire logic        hit_seg  = (PADDR == `LAG_OFF_SEG);
  wire logic        hit_xpt  = (PADDR == `LAG_OFF_XPT);
  wire logic        hit_addr = (PADDR == `LAG_OFF_ADDR);
  wire logic        hit_stat = (PADDR == `LAG_OFF_STAT);
  wire logic        hit_pcr  = (PADDR[11:6] == 6'(`LAG_OFF_PCR >> 6)) &&
                               (PADDR[1:0] == 2'b00);
  wire logic [3:0]  pcr_idx  = PADDR[5:2];
  wire logic        hit_ro   = hit_addr || hit_stat;
  wire logic        mapped   = hit_sts || hit_seg || hit_xpt || hit_ro || hit_pcr;
  wire logic [31:0] stat_v   = {pc_q, 8'h00, LEVEL, ring_q, refetch_q, shadow_q};
  wire logic [31:0] rd_v     =
    hit_sts  ? {16'h0000, sts_q} :
    hit_seg  ? {16'h0000, seg_q} :
    hit_xpt  ? {16'h0000, xpt_q} :
    hit_addr ? {6'h00, addr_q}   :
    hit_stat ? stat_v            :
    hit_pcr  ? {16'h0000, pcr_q[pcr_idx]} : 32'h00000000;

  always_ff @(posedge CLK) begin
    if (RST) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && (!mapped || (PWRITE && hit_ro));
      if (setup && !PWRITE) begin
        prdata_q <= rd_v;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      sts_q <= `LAG_RST_WORD;
      seg_q <= `LAG_RST_WORD;
      xpt_q <= `LAG_RST_WORD;
    end else if (wr_en) begin
      if (hit_sts) begin
        sts_q <= PWDATA[15:0];
      end
      if (hit_seg) begin
        seg_q <= PWDATA[15:0];
      end
      if (hit_xpt) begin
        xpt_q <= PWDATA[15:0];
      end
    end
  end

  // Paging control entries, one per level
  for (genvar i = 0; i < 16; i++) begin : g_pcr
    always_ff @(posedge CLK) begin
      if (RST) begin
        pcr_q[i] <= `LAG_RST_WORD;
      end else if (wr_en && hit_pcr && (pcr_idx == 4'(i))) begin
        pcr_q[i] <= PWDATA[15:0];
      end
    end
  end

  assign ADDR        = addr_q;
  assign ADDR_VALID  = valid_q;
  assign SHADOW      = shadow_q;
  assign RING        = ring_q;
  assign INSTR_FETCH = ifetch_q;
  assign REFETCH     = refetch_q;
  assign BUS_DO      = bus_do_q;
  assign BUS_OE_N    = bus_oe_n_q;
  assign PRDATA      = prdata_q;
  assign PREADY      = pready_q;
  assign PSLVERR     = pslverr_q;

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  AST_CMD_LATCH: assert property (
    (MEM_CMD == OP_ABS && !MISC_CMD[`LAG_MISC_WORD2]) ##1 1'b1 |-> ##1 ADDR_VALID && (ADDR.offset == $past(UWORD_ARG[9:0], 2)))
    else $error("Latched command did not yield its address");
  AST_HOLD: assert property (
    !cmd_go |=> $stable(ADDR) && $stable(SHADOW))
    else $error("Address changed without a command");
  AST_OFFSET: assert property (
    cmd_go |=> ADDR.offset == $past(sum[9:0]))
    else $error("Offset bits wrong");
  AST_VPAGE: assert property (
    cmd_go |=> ADDR.vpage == $past(sum[15:10]))
    else $error("Virtual page bits wrong");
  AST_TABLE: assert property (
    cmd_go && !paging_on_flag |=> ADDR.table_sel == 6'b000000)
    else $error("Page table selected while paging off");
  AST_SPARE: assert property (
    ADDR.spare == 4'h0)
    else $error("Spare address bits driven");
  AST_RING: assert property (
    cmd_go |=> RING == $past(pcr_q[LEVEL][1:0]))
    else $error("Ring not taken from current level entry");
  AST_REFETCH: assert property (
    RF_PC_WR |=> REFETCH && pc_q == $past(RF_DATA))
    else $error("PC write not reflected");
  AST_JUMP: assert property (
    is_jump && !RF_PC_WR |=> !BUS_OE_N && BUS_DO == pc_q ##1 BUS_OE_N || $past(is_jump))
    else $error("Jump target not driven for one cycle");
  AST_FETCH_INC: assert property (
    is_fetch && !RF_PC_WR |=> pc_q == $past(pc_q) + 16'h0001)
    else $error("Fetch did not advance PC copy");
  AST_SHADOW_FORCE: assert property (
    cmd_go && cmd_q.misc[`LAG_MISC_SHADOW] |=> SHADOW)
    else $error("Forced shadow access not flagged");
  AST_SHADOW_AREA: assert property (
    cmd_go && !paging_on_flag && (sum >= `LAG_SHADOW_BASE) |=> SHADOW)
    else $error("Shadow area access not flagged");
  AST_BUS_IDLE: assert property (
    !is_jump |=> BUS_OE_N)
    else $error("Internal bus driven without a jump");
  AST_REFUSED: assert property (
    go_q && !op_known |=> !ADDR_VALID && $stable(ADDR))
    else $error("Unknown command code produced an address");
  AST_X_COPY: assert property (
    RF_X_WR |=> x_q == $past(RF_DATA))
    else $error("X copy not loaded");

  COV_FETCH: cover property (is_fetch ##1 INSTR_FETCH);
  COV_JUMP: cover property (is_jump ##1 !BUS_OE_N);
  COV_SHADOW: cover property (cmd_go && shadow_d ##1 SHADOW);
  COV_REFUSED: cover property (go_q && !op_known ##1 !ADDR_VALID);

endmodule
`default_nettype wire

// ===== lag_pkg.sv
package lag_pkg;

  typedef enum logic [4:0] {
    OP_NONE  = 5'b00000,
    OP_FETCH = 5'b00001,
    OP_PCREL = 5'b00010,
    OP_XREL  = 5'b00011,
    OP_BREL  = 5'b00100,
    OP_BX    = 5'b00101,
    OP_ABS   = 5'b00110,
    OP_JUMP  = 5'b00111,
    OP_PCR   = 5'b01000,
    OP_SEG   = 5'b01001,
    OP_XPT   = 5'b01010
  } lag_op_e;

  typedef struct packed {
    logic [3:0] spare;
    logic [5:0] table_sel;
    logic [5:0] vpage;
    logic [9:0] offset;
  } lag_addr_s;

  typedef struct packed {
    logic [4:0]  misc;
    logic [4:0]  mem;
    logic [15:0] arg;
  } lag_cmd_s;

endpackage

// ===== lag_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
module lag_seq_model
  import lag_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Microcode fields and register-file writes
  output var  logic [4:0]  mem_cmd,
  output var  logic [4:0]  misc_cmd,
  output var  logic [15:0] uword_arg,
  output var  logic [2:0]  rf_wr,
  output var  logic [15:0] rf_data,
  // Shadow handoff
  input  wire logic        shadow,
  input  wire logic        addr_valid,
  output var  logic        shadow_lat_q
);
  initial begin
    mem_cmd = 5'h00;
    misc_cmd = 5'h00;
    uword_arg = 16'h0000;
    rf_wr = 3'h0;
    rf_data = 16'h0000;
    shadow_lat_q = 1'b0;
  end

  // Holds shadow for the memory control side
  always @(posedge clk) begin
    if (addr_valid) begin
      shadow_lat_q <= shadow;
    end
  end

  // Raw fields for one cycle, argument scrambled afterwards
  task automatic issue(input logic [4:0] op, input logic [4:0] mi, input logic [15:0] arg);
    mem_cmd <= op;
    misc_cmd <= mi;
    uword_arg <= arg;
    @(posedge clk);
    mem_cmd <= 5'h00;
    misc_cmd <= 5'h00;
    uword_arg <= ~arg;
  endtask

  // Write strobe {pc,x,b} for one cycle
  task automatic rf_write(input logic [2:0] sel, input logic [15:0] d);
    rf_wr <= sel;
    rf_data <= d;
    @(posedge clk);
    rf_wr <= 3'h0;
    rf_data <= ~d;
  endtask
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import lag_pkg::*;
;
  logic        CLK = 1'b0;
  logic        RST = 1'b1;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [3:0]  LEVEL = 4'h3;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  lag_addr_s   ADDR;
  logic        ADDR_VALID;
  logic        SHADOW;
  logic [1:0]  RING;
  logic        INSTR_FETCH;
  logic        REFETCH;
  logic [15:0] BUS_DO;
  logic        BUS_OE_N;
  logic [4:0]  mem_cmd;
  logic [4:0]  misc_cmd;
  logic [15:0] uword_arg;
  logic [2:0]  rf_wr;
  logic [15:0] rf_data;
  logic        sh_lat;
  logic [31:0] rv;
  logic        re;
  logic [1:0]  ring_e = 2'h2;
  int          bad_count = 0;
  int          cmp_count = 0;

  always #12.5 CLK = ~CLK;

  lag_logical_address_generator dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MEM_CMD(mem_cmd),
    .MISC_CMD(misc_cmd), .UWORD_ARG(uword_arg), .LEVEL(LEVEL), .RF_PC_WR(rf_wr[2]), .RF_X_WR(rf_wr[1]),
    .RF_B_WR(rf_wr[0]), .RF_DATA(rf_data), .ADDR(ADDR), .ADDR_VALID(ADDR_VALID), .SHADOW(SHADOW),
    .RING(RING), .INSTR_FETCH(INSTR_FETCH), .REFETCH(REFETCH), .BUS_DO(BUS_DO), .BUS_OE_N(BUS_OE_N));

  lag_seq_model seq (.clk(CLK), .mem_cmd(mem_cmd), .misc_cmd(misc_cmd), .uword_arg(uword_arg), .rf_wr(rf_wr),
    .rf_data(rf_data), .shadow(SHADOW), .addr_valid(ADDR_VALID), .shadow_lat_q(sh_lat));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) begin
      @(posedge CLK);
    end
    rv = PRDATA;
    re = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    chk("err", 32'(re), 32'(e));
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic e);
    apb(1'b0, a, 32'h0);
    chk("err", 32'(re), 32'(e));
    chk("rdata", rv, d);
  endtask

  task automatic cmd(input logic [4:0] op, mi, input logic [15:0] arg, a, input logic [5:0] ts, input logic sh);
    @(posedge CLK);
    seq.issue(op, mi, arg);
    @(posedge CLK);
    #1;
    chk("valid", 32'(ADDR_VALID), 32'h1);
    chk("addr", 32'(ADDR), {6'h0, 4'h0, ts, a});
    chk("shadow", 32'(SHADOW), 32'(sh));
    chk("ring", 32'(RING), 32'(ring_e));
    chk("fetch", 32'(INSTR_FETCH), 32'(op == 5'h01));
    chk("oe_n", 32'(BUS_OE_N), 32'(op != 5'h07));
    if (op == 5'h07) begin
      chk("bus", 32'(BUS_DO), 32'(a));
    end
    @(posedge CLK);
    #1;
    chk("valid", 32'(ADDR_VALID), 32'h0);
    chk("hold", 32'(ADDR), {6'h0, 4'h0, ts, a});
    chk("latch", 32'(sh_lat), 32'(sh));
  endtask

  task automatic results();
    $display("counts: %0d compared, %0d wrong", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #125000;
    bad_count++;
    results();
  end

  initial begin
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    #1;
    chk("oe_n", 32'(BUS_OE_N), 32'h1);
    chk("addr", 32'(ADDR), 32'h0);
    rd(12'h000, 32'h0, 1'b0);
    wr(12'h04C, 32'h0D42, 1'b0);
    wr(12'h050, 32'h0001, 1'b0);
    wr(12'h004, 32'h1000, 1'b0);
    wr(12'h008, 32'h0003, 1'b0);
    rd(12'h04C, 32'h0D42, 1'b0);
    wr(12'h00C, 32'h1, 1'b1);
    rd(12'h020, 32'h0, 1'b1);
    $display("test registers done");
    @(posedge CLK);
    seq.rf_write(3'b010, 16'h0100);
    @(posedge CLK);
    seq.rf_write(3'b001, 16'h0200);
    @(posedge CLK);
    seq.rf_write(3'b100, 16'h0400);
    #1;
    chk("refetch", 32'(REFETCH), 32'h1);
    cmd(OP_FETCH, 5'h00, 16'h0000, 16'h0400, 6'h00, 1'b0);
    chk("refetch", 32'(REFETCH), 32'h0);
    cmd(OP_PCREL, 5'h00, 16'h0010, 16'h0411, 6'h00, 1'b0);
    cmd(OP_XREL, 5'h00, 16'h0005, 16'h0105, 6'h00, 1'b0);
    cmd(OP_BREL, 5'h00, 16'h0007, 16'h0207, 6'h00, 1'b0);
    cmd(OP_BX, 5'h00, 16'h0000, 16'h0300, 6'h00, 1'b0);
    cmd(OP_ABS, 5'h00, 16'hFE05, 16'hFE05, 6'h00, 1'b1);
    cmd(OP_JUMP, 5'h00, 16'h0020, 16'h0421, 6'h00, 1'b0);
    cmd(OP_PCR, 5'h00, 16'h0001, 16'h0D43, 6'h00, 1'b0);
    cmd(OP_SEG, 5'h00, 16'h0002, 16'h1002, 6'h00, 1'b0);
    cmd(OP_XPT, 5'h00, 16'h0001, 16'h0004, 6'h00, 1'b0);
    cmd(OP_FETCH, 5'h00, 16'h0000, 16'h0421, 6'h00, 1'b0);
    rd(12'h00C, 32'h0421, 1'b0);
    rd(12'h010, 32'h0422_0038, 1'b0);
    @(posedge CLK);
    seq.issue(5'h0B, 5'h00, 16'h0040);
    @(posedge CLK);
    #1;
    chk("valid", 32'(ADDR_VALID), 32'h0);
    chk("addr", 32'(ADDR), 32'h0421);
    $display("test commands done");
    @(posedge CLK);
    LEVEL <= 4'h4;
    ring_e = 2'h1;
    cmd(OP_XREL, 5'h00, 16'h0005, 16'h0105, 6'h00, 1'b0);
    @(posedge CLK);
    LEVEL <= 4'h3;
    ring_e = 2'h2;
    wr(12'h000, 32'h4001, 1'b0);
    cmd(OP_XREL, 5'h00, 16'h0005, 16'h0105, 6'h1D, 1'b0);
    cmd(OP_XREL, 5'h01, 16'h0005, 16'h0105, 6'h1E, 1'b0);
    cmd(OP_ABS, 5'h04, 16'h0010, 16'h0010, 6'h1D, 1'b1);
    cmd(OP_ABS, 5'h00, 16'hFE05, 16'hFE05, 6'h1D, 1'b0);
    wr(12'h000, 32'h6001, 1'b0);
    cmd(OP_XREL, 5'h02, 16'h0005, 16'h0106, 6'h1D, 1'b0);
    cmd(OP_FETCH, 5'h01, 16'h0000, 16'h0422, 6'h1D, 1'b0);
    $display("test paging done");
    results();
  end
endmodule
`default_nettype wire
